// [pkg/eiu_pkg.sv]
// Constants, types and field layouts shared by the exception intercept unit.
package eiu_pkg;

    localparam int WB_ADDR_W = 8;

    typedef enum logic [2:0] {
        KIND_EXC,
        KIND_SOFT_INT,
        KIND_INTR,
        KIND_NMI,
        KIND_SMI,
        KIND_INIT,
        KIND_VINTR
    } eiu_kind_e;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_STATUS,
        ST_DECIDE
    } eiu_state_e;

    // Exception vectors.
    localparam logic [4:0] VEC_DE = 5'h00;
    localparam logic [4:0] VEC_OF = 5'h04;
    localparam logic [4:0] VEC_BR = 5'h05;
    localparam logic [4:0] VEC_DF = 5'h08;
    localparam logic [4:0] VEC_RSV9 = 5'h09;
    localparam logic [4:0] VEC_TS = 5'h0a;
    localparam logic [4:0] VEC_NP = 5'h0b;
    localparam logic [4:0] VEC_SS = 5'h0c;
    localparam logic [4:0] VEC_GP = 5'h0d;
    localparam logic [4:0] VEC_PF = 5'h0e;
    localparam logic [4:0] VEC_MF = 5'h10;
    localparam logic [4:0] VEC_AC = 5'h11;
    localparam logic [4:0] VEC_MC = 5'h12;
    localparam logic [4:0] VEC_XF = 5'h13;
    localparam logic [4:0] VEC_CP = 5'h15;
    localparam logic [4:0] VEC_SX = 5'h1e;

    localparam logic [7:0] OPC_INTO = 8'hce;
    localparam int FEAT_MC_OVERRIDE_BIT = 23;

    // Exit codes.
    localparam logic [7:0] EXIT_EXC_BASE = 8'h40;
    localparam logic [7:0] EXIT_INTR = 8'h60;
    localparam logic [7:0] EXIT_NMI = 8'h61;
    localparam logic [7:0] EXIT_SMI = 8'h62;
    localparam logic [7:0] EXIT_INIT = 8'h63;
    localparam logic [7:0] EXIT_VINTR = 8'h64;

    // Register byte offsets.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_EXC_MASK = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    localparam logic [7:0] REG_PRIM_LO = 8'h0c;
    localparam logic [7:0] REG_PRIM_HI = 8'h10;
    localparam logic [7:0] REG_SEC_LO = 8'h14;
    localparam logic [7:0] REG_SEC_HI = 8'h18;
    localparam logic [7:0] REG_FEATURE = 8'h1c;

    // Control register bits.
    localparam int CTL_INTR = 0;
    localparam int CTL_NMI = 1;
    localparam int CTL_SMI = 2;
    localparam int CTL_INIT = 3;
    localparam int CTL_VINTR = 4;
    localparam int CTL_SMM_LOCK = 5;
    localparam int CTL_HOST_MCE = 6;
    localparam int CTL_GUEST_MCE = 7;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [31:0] EXC_MASK_RESET = 32'h0000_0000;

    // SMI primary exit field layout.
    localparam int SMI_SRC_BIT = 0;
    localparam int SMI_MC_REDIRECT_FLAG_BIT = 1;
    localparam int SMI_SEG_LSB = 10;
    localparam int SMI_DIR_BIT = 32;
    localparam int SMI_VALID_BIT = 33;
    localparam int SMI_STR_BIT = 34;
    localparam int SMI_REP_BIT = 35;
    localparam int SMI_OPSZ_LSB = 36;
    localparam int SMI_ADSZ_LSB = 39;
    localparam int SMI_TF_BIT = 43;
    localparam int SMI_BRP_LSB = 44;
    localparam int SMI_PORT_LSB = 48;

    typedef struct packed {
        logic external;
        logic mc_redirect_flag;
        logic duringIo;
        logic [15:0] port;
        logic [3:0] io_breakpoint_match;
        logic tf;
        logic [2:0] addrSize;
        logic [2:0] opSize;
        logic rep;
        logic str;
        logic dirIn;
        logic [2:0] effective_segment;
        logic [63:0] rip;
    } eiu_smi_s;

endpackage

// [pkg/eiu_exit_if.sv]
// Interface carrying a latched event to the exit-information formatter and the fields back.
`timescale 1ns/1ps
interface eiu_exit_if;
    import eiu_pkg::*;
    eiu_kind_e kind;
    logic [4:0] vector;
    logic [31:0] errCode;
    logic [63:0] faultAddr;
    eiu_smi_s smi;
    logic [63:0] primary;
    logic [63:0] secondary;

    modport core (output kind, output vector, output errCode, output faultAddr, output smi,
                  input primary, input secondary);
    modport fmt (input kind, input vector, input errCode, input faultAddr, input smi,
                 output primary, output secondary);
endinterface

// [verilog/eiu_exit_format.sv]
// Formatter that builds the two exit-information fields from a latched event.
`timescale 1ns/1ps
module eiu_exit_format
    import eiu_pkg::*;
(
    eiu_exit_if.fmt ex
);

    // Fields the architecture leaves undefined are driven to zero so exits are repeatable.
    always_comb begin
        ex.primary = '0;
        ex.secondary = '0;
        case (ex.kind)
            KIND_EXC: begin
                case (ex.vector)
                    VEC_NP, VEC_SS, VEC_GP, VEC_AC, VEC_SX, VEC_CP: begin
                        ex.primary = {32'h0000_0000, ex.errCode};
                    end
                    VEC_PF: begin
                        ex.primary = {32'h0000_0000, ex.errCode};
                        ex.secondary = ex.faultAddr;
                    end
                    default: begin
                        ex.primary = '0;
                    end
                endcase
            end
            KIND_SMI: begin
                ex.primary[SMI_SRC_BIT] = ex.smi.external;
                ex.primary[SMI_MC_REDIRECT_FLAG_BIT] = ex.smi.mc_redirect_flag;
                if (ex.smi.duringIo) begin
                    ex.primary[SMI_VALID_BIT] = 1'b1;
                    ex.primary[SMI_PORT_LSB +: 16] = ex.smi.port;
                    ex.primary[SMI_BRP_LSB +: 4] = ex.smi.io_breakpoint_match;
                    ex.primary[SMI_TF_BIT] = ex.smi.tf;
                    ex.primary[SMI_ADSZ_LSB +: 3] = ex.smi.addrSize;
                    ex.primary[SMI_OPSZ_LSB +: 3] = ex.smi.opSize;
                    ex.primary[SMI_REP_BIT] = ex.smi.rep;
                    ex.primary[SMI_STR_BIT] = ex.smi.str;
                    ex.primary[SMI_DIR_BIT] = ex.smi.dirIn;
                    ex.primary[SMI_SEG_LSB +: 3] = ex.smi.effective_segment;
                    ex.secondary = ex.smi.rip;
                end
            end
            default: begin
                ex.primary = '0;
            end
        endcase
    end

endmodule

// [verilog/eiu_top.sv]
// Exception and interrupt intercept unit with a classic Wishbone register slave.
`timescale 1ns/1ps
module eiu_top
    import eiu_pkg::*;
#(
    parameter logic HOST_MC_OVERRIDE_CAP = 1'b1
)
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [WB_ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic evValid,
    input wire eiu_kind_e evKind,
    input wire logic [4:0] evVector,
    input wire logic [7:0] evOpcode,
    input wire logic [31:0] evErrCode,
    input wire logic [63:0] evFaultAddr,
    input wire eiu_smi_s evSmi,
    input wire logic statusWritten,
    input wire logic stiShadow,
    input wire logic globalInterruptFlag,
    input wire logic mcContainable,
    input wire logic mcExitReasonable,
    output logic evReady,
    output logic guestExit,
    output logic [7:0] exitCode,
    output logic [63:0] exitInfoPrimary,
    output logic [63:0] exitInfoSecondary,
    output logic ripOfInsn,
    output logic ripUndefined,
    output logic deliverEvent,
    output logic faultAddrWrite,
    output logic interruptHeld,
    output logic initPending,
    output logic initRelease,
    output logic vintrKept,
    output logic shutdownReq
);

    typedef struct packed {
        eiu_state_e fsm;
        logic ack;
        logic [31:0] datO;
        logic evReady;
        logic guestExit;
        logic [7:0] exitCode;
        logic [63:0] prim;
        logic [63:0] sec;
        logic ripOfInsn;
        logic ripUndefined;
        logic deliver;
        logic faultAddrWe;
        logic intrHeld;
        logic initPending;
        logic initRelease;
        logic vintrKept;
        logic shutdown;
        logic [7:0] ctrl;
        logic [31:0] excMask;
        eiu_kind_e kind;
        logic [4:0] vector;
        logic [7:0] opcode;
        logic [31:0] errCode;
        logic [63:0] faultAddr;
        eiu_smi_s smi;
    } eiu_top_s;

    eiu_top_s s;
    eiu_top_s next_s;

    eiu_exit_if exIf ();

    assign exIf.kind = s.kind;
    assign exIf.vector = s.vector;
    assign exIf.errCode = s.errCode;
    assign exIf.faultAddr = s.faultAddr;
    assign exIf.smi = s.smi;

    eiu_exit_format uFormat (
        .ex (exIf.fmt)
    );

    function automatic logic [31:0] wbMerge(input logic [31:0] old, input logic [31:0] wdata,
                                            input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = wdata[b*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic needsStatus(input eiu_kind_e kind, input logic [4:0] vec);
        return (kind == KIND_EXC) && (vec == VEC_MF || vec == VEC_XF || vec == VEC_MC);
    endfunction

    always_comb begin
        logic [31:0] rd;
        logic [31:0] ctrlWord;
        logic [31:0] feature;
        logic hit;
        logic doExit;
        logic doShut;
        logic initSet;
        logic [31:0] merged;
        rd = 32'h0000_0000;
        ctrlWord = {24'h00_0000, s.ctrl};
        merged = wbMerge(ctrlWord, wb_dat_i, wb_sel_i);
        feature = 32'h0000_0000;
        feature[FEAT_MC_OVERRIDE_BIT] = HOST_MC_OVERRIDE_CAP;
        hit = 1'b0;
        doExit = 1'b0;
        doShut = 1'b0;
        initSet = 1'b0;
        next_s = s;
        next_s.ack = 1'b0;
        next_s.guestExit = 1'b0;
        next_s.deliver = 1'b0;
        next_s.faultAddrWe = 1'b0;
        next_s.intrHeld = 1'b0;
        next_s.initRelease = 1'b0;
        next_s.vintrKept = 1'b0;
        next_s.shutdown = 1'b0;

        // Single-cycle slave: ack rises one edge after the strobe and drops the edge after.
        if (wb_cyc_i && wb_stb_i && !s.ack) begin
            next_s.ack = 1'b1;
            case (wb_adr_i)
                REG_CTRL: rd = ctrlWord;
                REG_EXC_MASK: rd = s.excMask;
                REG_STATUS: rd = {16'h0000, s.exitCode, 5'h00, s.fsm != ST_IDLE, 1'b0, s.initPending};
                REG_PRIM_LO: rd = s.prim[31:0];
                REG_PRIM_HI: rd = s.prim[63:32];
                REG_SEC_LO: rd = s.sec[31:0];
                REG_SEC_HI: rd = s.sec[63:32];
                REG_FEATURE: rd = feature;
                default: rd = 32'h0000_0000;
            endcase
            next_s.datO = rd;
            if (wb_we_i) begin
                case (wb_adr_i)
                    REG_CTRL: next_s.ctrl = merged[7:0];
                    REG_EXC_MASK: next_s.excMask = wbMerge(s.excMask, wb_dat_i, wb_sel_i);
                    default: next_s.ctrl = s.ctrl;
                endcase
            end
        end

        case (s.fsm)
            ST_IDLE: begin
                if (evValid) begin
                    next_s.kind = evKind;
                    next_s.vector = evVector;
                    next_s.opcode = evOpcode;
                    next_s.errCode = evErrCode;
                    next_s.faultAddr = evFaultAddr;
                    next_s.smi = evSmi;
                    // The FP, SIMD and machine-check cases wait for their own status writes.
                    if (needsStatus(evKind, evVector)) begin
                        next_s.fsm = ST_WAIT_STATUS;
                    end else begin
                        next_s.fsm = ST_DECIDE;
                    end
                end
            end
            ST_WAIT_STATUS: begin
                if (statusWritten) begin
                    next_s.fsm = ST_DECIDE;
                end
            end
            ST_DECIDE: begin
                if ((s.kind == KIND_NMI || s.kind == KIND_SMI) && stiShadow) begin
                    next_s.fsm = ST_DECIDE;
                end else begin
                    next_s.fsm = ST_IDLE;
                    case (s.kind)
                        KIND_EXC: begin
                            // Vector 9 has no intercept hardware behind its bit.
                            hit = s.excMask[s.vector] && (s.vector != VEC_RSV9);
                            if (s.vector == VEC_OF) begin
                                hit = hit && (s.opcode == OPC_INTO);
                            end
                            doExit = hit;
                            if (s.vector == VEC_MC) begin
                                if (!s.ctrl[CTL_GUEST_MCE]) begin
                                    doExit = hit && HOST_MC_OVERRIDE_CAP && s.ctrl[CTL_HOST_MCE]
                                             && mcContainable;
                                    doShut = !doExit;
                                end else if (hit && !mcExitReasonable) begin
                                    doExit = 1'b0;
                                    doShut = 1'b1;
                                end
                            end
                        end
                        KIND_SOFT_INT: doExit = 1'b0;
                        KIND_INTR: doExit = s.ctrl[CTL_INTR];
                        KIND_NMI: doExit = s.ctrl[CTL_NMI];
                        KIND_SMI: doExit = s.ctrl[CTL_SMI] && !s.ctrl[CTL_SMM_LOCK];
                        KIND_INIT: doExit = s.ctrl[CTL_INIT];
                        KIND_VINTR: doExit = s.ctrl[CTL_VINTR];
                        default: doExit = 1'b0;
                    endcase

                    if (doShut) begin
                        next_s.shutdown = 1'b1;
                    end else if (doExit) begin
                        next_s.guestExit = 1'b1;
                        next_s.prim = exIf.primary;
                        next_s.sec = exIf.secondary;
                        // Interrupt-based instructions report their own pointer; a task-state
                        // exit reports the switching instruction, one of the two allowed answers.
                        next_s.ripOfInsn = (s.kind == KIND_EXC) && (s.vector == VEC_OF ||
                                           s.vector == VEC_BR || s.vector == VEC_TS);
                        next_s.ripUndefined = (s.kind == KIND_EXC) && (s.vector == VEC_DF);
                        case (s.kind)
                            KIND_EXC: next_s.exitCode = 8'(EXIT_EXC_BASE + {3'b000, s.vector});
                            KIND_INTR: next_s.exitCode = EXIT_INTR;
                            KIND_NMI: next_s.exitCode = EXIT_NMI;
                            KIND_SMI: next_s.exitCode = EXIT_SMI;
                            KIND_INIT: next_s.exitCode = EXIT_INIT;
                            default: next_s.exitCode = EXIT_VINTR;
                        endcase
                        if (s.kind == KIND_INTR || s.kind == KIND_NMI || s.kind == KIND_SMI) begin
                            next_s.intrHeld = 1'b1;
                        end
                        if (s.kind == KIND_INIT) begin
                            initSet = 1'b1;
                        end
                        if (s.kind == KIND_VINTR) begin
                            next_s.vintrKept = 1'b1;
                        end
                    end else begin
                        next_s.deliver = 1'b1;
                        // The fault address register is written only once no intercept claimed it.
                        if (s.kind == KIND_EXC && s.vector == VEC_PF) begin
                            next_s.faultAddrWe = 1'b1;
                        end
                    end
                end
            end
            default: next_s.fsm = ST_IDLE;
        endcase

        // A new intercepted init wins over a release in the same cycle.
        if (initSet) begin
            next_s.initPending = 1'b1;
        end else if (s.initPending && globalInterruptFlag) begin
            next_s.initPending = 1'b0;
            next_s.initRelease = 1'b1;
        end

        next_s.evReady = (next_s.fsm == ST_IDLE);
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign wb_dat_o = s.datO;
    assign wb_ack_o = s.ack;
    assign evReady = s.evReady;
    assign guestExit = s.guestExit;
    assign exitCode = s.exitCode;
    assign exitInfoPrimary = s.prim;
    assign exitInfoSecondary = s.sec;
    assign ripOfInsn = s.ripOfInsn;
    assign ripUndefined = s.ripUndefined;
    assign deliverEvent = s.deliver;
    assign faultAddrWrite = s.faultAddrWe;
    assign interruptHeld = s.intrHeld;
    assign initPending = s.initPending;
    assign initRelease = s.initRelease;
    assign vintrKept = s.vintrKept;
    assign shutdownReq = s.shutdown;

endmodule

// [tb/eiu_top_props.sv]
// Concurrent checks on the intercept unit's top-level ports.
`timescale 1ns/1ps
module eiu_top_props
    import eiu_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic evValid,
    input wire logic evReady,
    input wire eiu_kind_e evKind,
    input wire logic [31:0] evErrCode,
    input wire logic [63:0] evFaultAddr,
    input wire logic guestExit,
    input wire logic [7:0] exitCode,
    input wire logic [63:0] exitInfoPrimary,
    input wire logic [63:0] exitInfoSecondary,
    input wire logic deliverEvent,
    input wire logic faultAddrWrite,
    input wire logic interruptHeld,
    input wire logic vintrKept,
    input wire logic initPending,
    input wire logic initRelease,
    input wire logic globalInterruptFlag
);
    logic take;
    logic [31:0] err;
    logic [63:0] addr;
    // The event data is latched at the take, since the source may change it right after.
    assign take = evValid && evReady;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            err <= '0;
            addr <= '0;
        end else if (take) begin
            err <= evErrCode;
            addr <= evFaultAddr;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    a_pf_no_write: assert property (guestExit |-> !faultAddrWrite)
        else $error("Fault address written on an intercepted exit.");
    a_write_on_delivery: assert property (faultAddrWrite |-> deliverEvent)
        else $error("Fault address written without delivery.");
    a_pf_fields: assert property (guestExit && exitCode == 8'h4e |->
        exitInfoPrimary == {32'h0000_0000, err} && exitInfoSecondary == addr)
        else $error("Page fault exit fields wrong.");
    a_err_primary: assert property (guestExit && exitCode inside {8'h4b, 8'h4c, 8'h4d, 8'h51, 8'h55, 8'h5e}
        |-> exitInfoPrimary[31:0] == err)
        else $error("Error code missing from primary field.");
    a_soft_no_exit: assert property (take && evKind == KIND_SOFT_INT |-> ##2 deliverEvent && !guestExit)
        else $error("Software interrupt caused an exit.");
    a_intr_held: assert property (guestExit && exitCode == EXIT_INTR |-> interruptHeld)
        else $error("Intercepted interrupt not held.");
    a_vintr_kept: assert property (guestExit && exitCode == EXIT_VINTR |-> vintrKept)
        else $error("Virtual interrupt not kept pending.");
    a_init_hold: assert property (initPending && !globalInterruptFlag |=> initPending && !initRelease)
        else $error("Init released without the global flag.");
    a_init_free: assert property (initPending && globalInterruptFlag |=> initRelease || guestExit)
        else $error("Init not released after the global flag.");
    c_smi_exit: cover property (guestExit && exitCode == EXIT_SMI);
    c_init_release: cover property (initRelease);
    c_fault_write: cover property (faultAddrWrite);
endmodule
bind eiu_top eiu_top_props props (.clk_sys, .rst_b, .evValid, .evReady, .evKind, .evErrCode, .evFaultAddr,
    .guestExit, .exitCode, .exitInfoPrimary, .exitInfoSecondary, .deliverEvent, .faultAddrWrite,
    .interruptHeld, .vintrKept, .initPending, .initRelease, .globalInterruptFlag);

// [tb/test_exception_intercept_exit_info.sv]
// Self-checking bench driving the intercept unit through its register bus and event port.
`timescale 1ns/1ps
module test_exception_intercept_exit_info
    import eiu_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, evValid = 1'b0;
    logic [7:0] wb_adr_i = 8'h00, evOpcode = 8'h00, exitCode;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = '0, evErrCode = '0, wb_dat_o, rdat;
    logic [63:0] evFaultAddr = '0, exitInfoPrimary, exitInfoSecondary;
    eiu_kind_e evKind = KIND_EXC;
    logic [4:0] evVector = 5'h00;
    eiu_smi_s evSmi = '0;
    logic statusWritten = 1'b1, stiShadow = 1'b0, globalInterruptFlag = 1'b0;
    logic mcContainable = 1'b1, mcExitReasonable = 1'b1;
    logic wb_ack_o, evReady, guestExit, ripOfInsn, ripUndefined, deliverEvent, faultAddrWrite;
    logic interruptHeld, initPending, initRelease, vintrKept, shutdownReq, g, d, s, f, h;
    int bad_count = 0, tests_run = 0, cycles = 0;
    logic [4:0] vl [14] = '{VEC_NP, VEC_SS, VEC_GP, VEC_AC, VEC_SX, VEC_CP, VEC_PF, VEC_DE, 5'h06, 5'h07,
        VEC_BR, VEC_DF, VEC_TS, VEC_OF};
    logic [4:0] vm [3] = '{VEC_MF, VEC_XF, VEC_MC};
    eiu_kind_e kl [3] = '{KIND_INTR, KIND_NMI, KIND_VINTR};
    logic [7:0] kc [3] = '{EXIT_INTR, EXIT_NMI, EXIT_VINTR};

    eiu_top DUT (.clk_sys, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
        .wb_dat_o, .wb_ack_o, .evValid, .evKind, .evVector, .evOpcode, .evErrCode, .evFaultAddr, .evSmi,
        .statusWritten, .stiShadow, .globalInterruptFlag, .mcContainable, .mcExitReasonable, .evReady,
        .guestExit, .exitCode, .exitInfoPrimary, .exitInfoSecondary, .ripOfInsn, .ripUndefined,
        .deliverEvent, .faultAddrWrite, .interruptHeld, .initPending, .initRelease, .vintrKept, .shutdownReq);

    always #5 clk_sys = ~clk_sys;

    task results;
        if (bad_count == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            results;
        end
    end

    task chk(input string n, input logic [63:0] e, input logic [63:0] v);
        tests_run++;
        if (v !== e) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", n, e, v);
        end
    endtask

    task wb(input logic w, input logic [7:0] a, input logic [31:0] dt);
        @(posedge clk_sys);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= dt;
        // Registered outputs are looked at on the falling edge, clear of the launching edge.
        do @(negedge clk_sys); while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        @(posedge clk_sys);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    // Gating inputs are released only after the hold cycles, so an early answer is caught.
    task ev(input eiu_kind_e k, input logic [4:0] v, input int hold);
        @(posedge clk_sys);
        evValid <= 1'b1;
        evKind <= k;
        evVector <= v;
        do @(negedge clk_sys); while (evReady !== 1'b1);
        @(posedge clk_sys);
        evValid <= 1'b0;
        repeat (hold) begin
            @(negedge clk_sys);
            chk("early", 64'h0, 64'(guestExit | deliverEvent | shutdownReq));
        end
        @(posedge clk_sys);
        statusWritten <= 1'b1;
        stiShadow <= 1'b0;
        do @(negedge clk_sys); while ((guestExit | deliverEvent | shutdownReq) !== 1'b1);
        g = guestExit;
        d = deliverEvent;
        s = shutdownReq;
        f = faultAddrWrite;
        h = interruptHeld | vintrKept;
        @(posedge clk_sys);
    endtask

    initial begin
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        wb(1'b0, REG_CTRL, 32'h0000_0000);
        chk("ctrl", 64'h0, 64'(rdat));
        wb(1'b1, REG_FEATURE, 32'h0000_0000);
        wb(1'b0, REG_FEATURE, 32'h0000_0000);
        chk("feature", 64'h0080_0000, 64'(rdat));
        wb(1'b0, 8'h40, 32'h0000_0000);
        chk("unmapped", 64'h0, 64'(rdat));
        wb(1'b1, REG_EXC_MASK, 32'hffff_ffff);
        wb(1'b1, REG_CTRL, 32'h0000_005f);
        wb(1'b0, REG_CTRL, 32'h0000_0000);
        chk("ctrl", 64'h5f, 64'(rdat));
        evOpcode <= OPC_INTO;
        for (int i = 0; i < 14; i++) begin
            evErrCode <= 32'hbe00_0000 + 32'(i);
            evFaultAddr <= {32'h1234_5678, 32'(i)};
            ev(KIND_EXC, vl[i], 0);
            chk("exit", 64'h1, 64'(g));
            chk("code", 64'(8'h40 + 8'(vl[i])), 64'(exitCode));
            chk("prim", i < 7 ? 64'(32'hbe00_0000 + 32'(i)) : 64'h0, exitInfoPrimary);
            chk("sec", i == 6 ? {32'h1234_5678, 32'(i)} : 64'h0, exitInfoSecondary);
            chk("ripu", 64'(vl[i] == VEC_DF), 64'(ripUndefined));
            chk("ripi", 64'(vl[i] == VEC_TS || vl[i] == VEC_OF || vl[i] == VEC_BR), 64'(ripOfInsn));
        end
        evOpcode <= 8'hcd;
        ev(KIND_EXC, VEC_OF, 0);
        chk("ofother", 64'h1, 64'(d));
        ev(KIND_EXC, VEC_RSV9, 0);
        chk("vec9", 64'h1, 64'(d));
        ev(KIND_SOFT_INT, VEC_GP, 0);
        chk("soft", 64'h1, 64'(d));
        wb(1'b1, REG_EXC_MASK, 32'hffff_bfff);
        ev(KIND_EXC, VEC_PF, 0);
        chk("faddr", 64'h1, 64'(f));
        for (int i = 0; i < 3; i++) begin
            statusWritten <= 1'b0;
            ev(KIND_EXC, vm[i], 4);
            chk("fpcode", 64'(8'h40 + 8'(vm[i])), 64'(exitCode));
        end
        mcContainable <= 1'b0;
        ev(KIND_EXC, VEC_MC, 0);
        chk("mcshut", 64'h1, 64'(s));
        for (int i = 0; i < 3; i++) begin
            stiShadow <= (i == 1);
            ev(kl[i], VEC_GP, i == 1 ? 3 : 0);
            chk("intcode", 64'(kc[i]), 64'(exitCode));
            chk("held", 64'h1, 64'(h));
        end
        evSmi <= '{1'b1, 1'b0, 1'b1, 16'h03f8, 4'h5, 1'b1, 3'h2, 3'h1, 1'b1, 1'b0, 1'b1, 3'h3, 64'h0040_1000};
        stiShadow <= 1'b1;
        ev(KIND_SMI, 5'h00, 3);
        chk("smip", 64'h03f8_591b_0000_0c01, exitInfoPrimary);
        chk("smis", 64'h0040_1000, exitInfoSecondary);
        wb(1'b1, REG_CTRL, 32'h0000_007f);
        ev(KIND_SMI, 5'h00, 0);
        chk("smm_lock_a", 64'h1, 64'(d));
        ev(KIND_INIT, 5'h00, 0);
        chk("initcode", 64'(EXIT_INIT), 64'(exitCode));
        wb(1'b0, REG_STATUS, 32'h0000_0000);
        chk("status", 64'h6301, 64'(rdat));
        globalInterruptFlag <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk("initdone", 64'h0, 64'(initPending));
        results;
    end
endmodule
